// ==== design/wdt_supervisor_regs.vh ====
// Register offsets, field positions, reset values and timing constants of the watchdog supervisor.
`ifndef WDT_SUPERVISOR_REGS_VH
`define WDT_SUPERVISOR_REGS_VH

// Register offsets.
`define REG_MODE_PRESCALE 7'h13
`define REG_TIMER_ERRCNT 7'h14
`define REG_ERROR_THRESHOLD 7'h16
`define REG_IRQ_STATUS 7'h17

// Fields of the mode and prescale register.
`define MODE_SEL_HI 7
`define MODE_SEL_LO 6
`define PRESCALE_HI 5
`define PRESCALE_LO 4

// Fields of the timer and error count register.
`define TIMER_HI 7
`define TIMER_LO 5
`define ERRCNT_HI 4
`define ERRCNT_LO 1
`define STANDBY_DIS_BIT 0

// Fields of the threshold and interrupt status registers.
`define THRESH_HI 7
`define THRESH_LO 6
`define IRQ_WD_BIT 0

// Watchdog style encodings.
`define WD_MODE_OFF 2'h0
`define WD_MODE_TIMEOUT 2'h1
`define WD_MODE_WINDOW 2'h2

// Reset values.
`define MODE_PRESCALE_RESET 8'h80
`define TIMER_ERRCNT_RESET 8'h02
`define ERROR_THRESHOLD_RESET 8'h00
`define ERRCNT_RESET 4'h1

// Trip counts selected by the threshold field.
`define TRIP_SEL0 4'h1
`define TRIP_SEL1 4'h5
`define TRIP_SEL2 4'h9
`define TRIP_SEL3 4'hf

// Operating modes reported by the mode controller.
`define OPMODE_OTHER 2'h0
`define OPMODE_STANDBY 2'h1
`define OPMODE_NORMAL 2'h2
`define OPMODE_FAST 2'h3

// Timing figures in their own units and the clock rate.
`define CLK_FREQ_KHZ 100000
`define TRIG_FILTER_NS 1000
`define RESET_PULSE_US 2000
`define PIN_WINDOW_LOW_MS 10'd64
`define PIN_WINDOW_OPEN_MS 10'd128
`define PIN_WINDOW_HIGH_MS 10'd256

`endif

// ==== design/spi_register_port.v ====
// Serial register port: 16-bit frames, command byte then data byte, MSB first, SPI mode 0.
`default_nettype none

module spi_register_port (
    // Clock and reset.
    input wire clk,
    input wire reset_n,
    // Serial pins.
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_mosi,
    output reg spi_miso,
    // Register side.
    output reg [6:0] reg_addr,
    output reg [7:0] reg_wdata,
    output reg reg_write,
    input wire [7:0] reg_rdata
);

    reg [1:0] sclk_sync;
    reg [1:0] cs_sync;
    reg [1:0] mosi_sync;
    reg sclk_last;
    reg [4:0] bit_count;
    reg [14:0] shift_in;
    reg [7:0] shift_out;
    wire sclk_rise;
    wire sclk_fall;

    // Pins come from the host's domain, so each passes two flip-flops first.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_sync <= 2'h0;
            cs_sync <= 2'h3;
            mosi_sync <= 2'h0;
            sclk_last <= 1'b0;
        end else begin
            sclk_sync <= {sclk_sync[0], spi_sclk};
            cs_sync <= {cs_sync[0], spi_cs_n};
            mosi_sync <= {mosi_sync[0], spi_mosi};
            sclk_last <= sclk_sync[1];
        end
    end

    assign sclk_rise = sclk_sync[1] & ~sclk_last;
    assign sclk_fall = ~sclk_sync[1] & sclk_last;

    // Shift on rising edges, answer on falling edges; a frame cut short writes nothing.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_count <= 5'h00;
            shift_in <= 15'h0000;
            shift_out <= 8'h00;
            spi_miso <= 1'b0;
            reg_addr <= 7'h00;
            reg_wdata <= 8'h00;
            reg_write <= 1'b0;
        end else begin
            reg_write <= 1'b0;
            if (cs_sync[1]) begin
                bit_count <= 5'h00;
                spi_miso <= 1'b0;
            end else begin
                if (sclk_rise && bit_count != 5'h10) begin
                    shift_in <= {shift_in[13:0], mosi_sync[1]};
                    bit_count <= bit_count + 5'h01;
                    if (bit_count == 5'h07) begin
                        reg_addr <= {shift_in[5:0], mosi_sync[1]};
                    end
                    if (bit_count == 5'h0f) begin
                        reg_wdata <= {shift_in[6:0], mosi_sync[1]};
                        reg_write <= shift_in[14];
                    end
                end
                if (sclk_fall) begin
                    if (bit_count == 5'h08) begin
                        spi_miso <= reg_rdata[7];
                        shift_out <= {reg_rdata[6:0], 1'b0};
                    end else begin
                        spi_miso <= shift_out[7];
                        shift_out <= {shift_out[6:0], 1'b0};
                    end
                end
            end
        end
    end

endmodule

`default_nettype wire

// ==== design/windowed_watchdog_supervisor.v ====
// Windowed watchdog supervisor with error counter, reset pulse generation and serial register access.
//
// Functional notes
// RULE1 - SPI control: errors count the counter up.
// RULE2 - Error counter starts at one after reset.
// RULE3 - Good trigger counts down, saturating at zero.
// RULE4 - Trip: restart mode, counter one, reset low.
// RULE5 - Pulse over: back to standby, reset released.
// RULE6 - Threshold field selects trip 1, 5, 9, 15.
// RULE7 - Error count readable in timer register.
// RULE8 - Pin control: watchdog reset low per error.
// RULE9 - Trip count one: first failure restarts.
// RULE10 - Bad trigger sets interrupt flag, output low.
// RULE11 - Pin control: strap picks total window.
// RULE12 - Window split equally closed then open.
// RULE13 - Both edges trigger; short glitches filtered.
// RULE14 - Trigger pulse is two events, an error.
// RULE15 - Mode field picks timeout or window style.
// RULE16 - Prescaler and timer fields set length.
// RULE17 - Timeout mode: trigger anytime before expiry.
// RULE18 - Host allows ten percent oscillator tolerance.
// RULE19 - Host uses timeout for sub-16 ms triggering.
// RULE20 - Mode field zero disables the watchdog.
// RULE21 - Config change reloads counter, restarts timers.
// RULE22 - Entering fast, normal, standby restarts timing.
// RULE23 - Fast mode failure only sets interrupt.
// RULE24 - Trigger in closed half is incorrect.
`include "wdt_supervisor_regs.vh"
`default_nettype none

module windowed_watchdog_supervisor #(
    parameter CYCLES_PER_MS = `CLK_FREQ_KHZ / 1000 * 1000,
    parameter RESET_PULSE_CYCLES = `RESET_PULSE_US * (`CLK_FREQ_KHZ / 1000),
    parameter FILTER_CYCLES = (`TRIG_FILTER_NS * (`CLK_FREQ_KHZ / 1000) + 999) / 1000
) (
    // Clock and reset.
    input wire clk,
    input wire reset_n,
    // Control straps, sampled once after reset release.
    input wire spi_control_strap,
    input wire window_size_strap_high,
    input wire window_size_strap_low,
    // Operating mode from the mode controller, same clock.
    input wire [1:0] op_mode,
    // Trigger pin from the host.
    input wire trigger_input,
    // Serial register port.
    input wire spi_sclk,
    input wire spi_cs_n,
    input wire spi_mosi,
    output wire spi_miso,
    // Outputs to the host.
    output reg system_reset_out_n,
    output reg watchdog_reset_out_n,
    output reg interrupt_out_n,
    output reg restart_active
);

    // Reset image of the timer register, so that its timer field can be cut out at its own width.
    localparam [7:0] TIMER_ERRCNT_INIT = `TIMER_ERRCNT_RESET;

    wire [6:0] reg_addr;
    wire [7:0] reg_wdata;
    wire reg_write;
    reg [7:0] reg_rdata;
    reg [7:0] mode_prescale;
    reg [2:0] timer_sel;
    reg standby_disable;
    reg [1:0] thresh_sel;
    reg irq_flag;
    reg [3:0] err_count;
    reg [3:0] next_err_count;
    reg [1:0] strap_sync;
    reg [1:0] win_hi_sync;
    reg [1:0] win_lo_sync;
    reg [1:0] settle;
    reg spi_mode;
    reg [1:0] pin_window;
    reg [1:0] trig_sync;
    reg trig_level;
    reg [15:0] filter_count;
    reg [31:0] ms_count;
    reg [9:0] elapsed_ms;
    reg [31:0] pulse_count;
    reg [1:0] last_op_mode;
    reg [9:0] total_ms;
    reg [3:0] trip_count;
    reg [1:0] wd_style;
    wire trig_edge;
    wire ms_tick;
    wire wd_enabled;
    wire cfg_write;
    wire mode_entry;
    wire restart_timing;
    wire closed_part;
    wire good_trigger;
    wire bad_trigger;
    wire missed_window;
    wire wd_error;
    wire trip;

    // The serial port reaches the register file.
    spi_register_port u_spi_port (
        .clk(clk),
        .reset_n(reset_n),
        .spi_sclk(spi_sclk),
        .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_write(reg_write),
        .reg_rdata(reg_rdata)
    );

    // Straps are synchronised, then caught once the chain has settled after reset.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            strap_sync <= 2'h0;
            win_hi_sync <= 2'h0;
            win_lo_sync <= 2'h0;
            settle <= 2'h0;
            spi_mode <= 1'b0;
            pin_window <= 2'h0;
        end else begin
            strap_sync <= {strap_sync[0], spi_control_strap};
            win_hi_sync <= {win_hi_sync[0], window_size_strap_high};
            win_lo_sync <= {win_lo_sync[0], window_size_strap_low};
            if (settle != 2'h3) begin
                settle <= settle + 2'h1;
            end
            if (settle == 2'h2) begin
                spi_mode <= strap_sync[1];
                pin_window <= {win_hi_sync[1], win_lo_sync[1]}; // RULE11
            end
        end
    end

    // Trigger pin: two flip-flops, then a level filter; either edge of the filtered level counts.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trig_sync <= 2'h0;
            trig_level <= 1'b0;
            filter_count <= 16'h0000;
        end else begin
            trig_sync <= {trig_sync[0], trigger_input};
            if (trig_sync[1] == trig_level || settle != 2'h3) begin
                filter_count <= 16'h0000;
                trig_level <= (settle != 2'h3) ? trig_sync[1] : trig_level;
            end else if (filter_count == FILTER_CYCLES[15:0] - 16'h0001) begin
                filter_count <= 16'h0000;
                trig_level <= trig_sync[1]; // RULE13
            end else begin
                filter_count <= filter_count + 16'h0001;
            end
        end
    end

    // A change of the filtered level is one trigger event, rising or falling.
    assign trig_edge = (trig_sync[1] != trig_level) && (filter_count == FILTER_CYCLES[15:0] - 16'h0001)
        && (settle == 2'h3); // RULE13

    // Style and length: pin control always runs a window from the strap.
    always @* begin
        wd_style = spi_mode ? mode_prescale[`MODE_SEL_HI:`MODE_SEL_LO] : `WD_MODE_WINDOW; // RULE15
        if (wd_style == 2'h3) begin
            wd_style = `WD_MODE_WINDOW;
        end
        if (spi_mode) begin
            total_ms = {3'h0, ({1'b0, timer_sel} + 4'h1), 3'h0}
                << mode_prescale[`PRESCALE_HI:`PRESCALE_LO]; // RULE16
        end else begin
            case (pin_window)
                2'h1: total_ms = `PIN_WINDOW_LOW_MS; // RULE11
                2'h2: total_ms = `PIN_WINDOW_HIGH_MS;
                default: total_ms = `PIN_WINDOW_OPEN_MS;
            endcase
        end
        case (thresh_sel)
            2'h0: trip_count = `TRIP_SEL0; // RULE6
            2'h1: trip_count = `TRIP_SEL1;
            2'h2: trip_count = `TRIP_SEL2;
            default: trip_count = `TRIP_SEL3;
        endcase
    end

    // Running conditions; the watchdog halts outside the supervised modes and during restart.
    assign wd_enabled = (!spi_mode || wd_style != `WD_MODE_OFF) // RULE20
        && (op_mode != `OPMODE_OTHER) && !restart_active && (settle == 2'h3)
        && !(spi_mode && standby_disable && op_mode == `OPMODE_STANDBY);
    assign cfg_write = reg_write && spi_mode && (reg_addr == `REG_MODE_PRESCALE
        || reg_addr == `REG_TIMER_ERRCNT || reg_addr == `REG_ERROR_THRESHOLD);
    assign mode_entry = (op_mode != last_op_mode) && (op_mode != `OPMODE_OTHER);
    assign restart_timing = cfg_write || mode_entry || !wd_enabled; // RULE21 RULE22

    // Timer events. Hazard: a trigger in the closing millisecond of a window still counts as good.
    assign closed_part = (wd_style == `WD_MODE_WINDOW) && (elapsed_ms < (total_ms >> 1)); // RULE12
    assign good_trigger = wd_enabled && !restart_timing && trig_edge && !closed_part; // RULE17
    assign bad_trigger = wd_enabled && !restart_timing && trig_edge && closed_part; // RULE24 RULE14
    assign missed_window = wd_enabled && !restart_timing && !trig_edge && ms_tick
        && (elapsed_ms + 10'h001 >= total_ms);
    assign wd_error = bad_trigger || missed_window;
    assign ms_tick = (ms_count == CYCLES_PER_MS - 1);

    // Millisecond base and elapsed window time; every trigger or error starts a fresh window.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ms_count <= 32'h00000000;
            elapsed_ms <= 10'h000;
            last_op_mode <= `OPMODE_OTHER;
        end else begin
            last_op_mode <= op_mode;
            if (restart_timing || trig_edge || wd_error) begin
                ms_count <= 32'h00000000; // RULE22
                elapsed_ms <= 10'h000;
            end else if (ms_tick) begin
                ms_count <= 32'h00000000;
                elapsed_ms <= elapsed_ms + 10'h001;
            end else begin
                ms_count <= ms_count + 32'h00000001;
            end
        end
    end

    // Error counter arithmetic; pin control trips on every error outside fast mode.
    always @* begin
        next_err_count = err_count;
        if (good_trigger && err_count != 4'h0) begin
            next_err_count = err_count - 4'h1; // RULE3
        end else if (wd_error && err_count != 4'hf) begin
            next_err_count = err_count + 4'h1; // RULE1
        end
    end

    assign trip = wd_error && (op_mode != `OPMODE_FAST) // RULE23
        && (!spi_mode || next_err_count >= trip_count); // RULE9 RULE14

    // Error counter, restart mode and the reset pulses.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            err_count <= `ERRCNT_RESET; // RULE2
            restart_active <= 1'b0;
            pulse_count <= 32'h00000000;
            system_reset_out_n <= 1'b1;
            watchdog_reset_out_n <= 1'b1;
        end else begin
            if (cfg_write || trip) begin
                err_count <= `ERRCNT_RESET; // RULE21 RULE4
            end else if (spi_mode && op_mode != `OPMODE_FAST) begin
                err_count <= next_err_count; // RULE1 RULE3
            end
            if (trip) begin
                restart_active <= 1'b1; // RULE4
                pulse_count <= 32'h00000000;
                system_reset_out_n <= 1'b0;
                watchdog_reset_out_n <= spi_mode; // RULE8
            end else if (restart_active) begin
                if (pulse_count == RESET_PULSE_CYCLES - 1) begin
                    restart_active <= 1'b0; // RULE5
                    system_reset_out_n <= 1'b1;
                    watchdog_reset_out_n <= 1'b1;
                end else begin
                    pulse_count <= pulse_count + 32'h00000001;
                end
            end
        end
    end

    // Registers; writing a one to the interrupt flag clears it, but a new error wins.
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_prescale <= `MODE_PRESCALE_RESET;
            timer_sel <= TIMER_ERRCNT_INIT[`TIMER_HI:`TIMER_LO];
            standby_disable <= 1'b0;
            thresh_sel <= 2'h0;
            irq_flag <= 1'b0;
            interrupt_out_n <= 1'b1;
        end else begin
            if (reg_write && reg_addr == `REG_MODE_PRESCALE) begin
                mode_prescale <= reg_wdata;
            end
            if (reg_write && reg_addr == `REG_TIMER_ERRCNT) begin
                timer_sel <= reg_wdata[`TIMER_HI:`TIMER_LO];
                standby_disable <= reg_wdata[`STANDBY_DIS_BIT];
            end
            if (reg_write && reg_addr == `REG_ERROR_THRESHOLD) begin
                thresh_sel <= reg_wdata[`THRESH_HI:`THRESH_LO];
            end
            if (wd_error) begin
                irq_flag <= 1'b1; // RULE10 RULE23
            end else if (reg_write && reg_addr == `REG_IRQ_STATUS && reg_wdata[`IRQ_WD_BIT]) begin
                irq_flag <= 1'b0;
            end
            interrupt_out_n <= !(wd_error || (irq_flag
                && !(reg_write && reg_addr == `REG_IRQ_STATUS && reg_wdata[`IRQ_WD_BIT]))); // RULE10
        end
    end

    // Read mux; unmapped addresses read as zero.
    always @* begin
        case (reg_addr)
            `REG_MODE_PRESCALE: reg_rdata = mode_prescale;
            `REG_TIMER_ERRCNT: reg_rdata = {timer_sel, err_count, standby_disable}; // RULE7
            `REG_ERROR_THRESHOLD: reg_rdata = {thresh_sel, 6'h00};
            `REG_IRQ_STATUS: reg_rdata = {7'h00, irq_flag};
            default: reg_rdata = 8'h00;
        endcase
    end

endmodule

`default_nettype wire

// ==== dv/windowed_watchdog_supervisor_assertions.sv ====
// Concurrent checks on the reset, restart and interrupt outputs of the watchdog supervisor.
`default_nettype none

module wdt_supervisor_checker #(
    parameter int RESET_PULSE_CYCLES = 200000
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Inputs seen by the design.
    input wire logic spi_control_strap,
    input wire logic [1:0] op_mode,
    // Outputs to the host.
    input wire logic system_reset_out_n,
    input wire logic watchdog_reset_out_n,
    input wire logic interrupt_out_n,
    input wire logic restart_active
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // Counts low cycles of the reset output, since a repetition cannot reach the full pulse length.
    logic [31:0] low_cnt;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            low_cnt <= 32'h0;
        end else if (!system_reset_out_n) begin
            low_cnt <= low_cnt + 32'h1;
        end else begin
            low_cnt <= 32'h0;
        end
    end

    // Steps of a trip: entry with the flag raised, then a held restart.
    sequence trip_entry;
        restart_active && !interrupt_out_n;
    endsequence
    sequence hold_restart;
        (restart_active && !system_reset_out_n) [*8];
    endsequence

    pulse_len_a: assert property ($rose(system_reset_out_n) |-> low_cnt == RESET_PULSE_CYCLES)
        else $error("reset pulse length wrong");
    restart_low_a: assert property (restart_active |-> !system_reset_out_n)
        else $error("restart without reset low");
    release_exit_a: assert property ($rose(system_reset_out_n) |-> $past(restart_active) && !restart_active)
        else $error("release not tied to restart exit");
    trip_entry_a: assert property ($fell(system_reset_out_n) |-> trip_entry)
        else $error("trip without restart and interrupt");
    hold_restart_a: assert property ($fell(system_reset_out_n) |-> hold_restart)
        else $error("restart not held");
    fast_quiet_a: assert property ($stable(op_mode) && op_mode == 2'h3 |-> !$fell(system_reset_out_n))
        else $error("reset in fast mode");
    wdr_follow_a: assert property (spi_control_strap ? watchdog_reset_out_n : watchdog_reset_out_n == system_reset_out_n)
        else $error("watchdog reset output wrong");
    irq_latched_a: assert property ($fell(interrupt_out_n) |-> !interrupt_out_n [*8])
        else $error("interrupt not held");
endmodule

`default_nettype wire

// ==== dv/host_trigger_model.sv ====
// Host controller model that toggles the watchdog trigger pin on command.
`default_nettype none

module host_trigger_model #(
    parameter int PULSE_GAP = 20
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Commands from the bench.
    input wire logic do_edge,
    input wire logic do_pulse,
    // Trigger pin.
    output var logic trigger_input
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] gap_cnt;

    // A single edge is the normal trigger; a pulse adds a return edge, which the device must see as an error.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trigger_input <= 1'b0;
            gap_cnt <= 8'h00;
        end else if (do_edge || do_pulse) begin
            trigger_input <= !trigger_input;
            gap_cnt <= do_pulse ? PULSE_GAP[7:0] : 8'h00;
        end else if (gap_cnt == 8'h01) begin
            trigger_input <= !trigger_input;
            gap_cnt <= 8'h00;
        end else if (gap_cnt != 8'h00) begin
            gap_cnt <= gap_cnt - 8'h01;
        end
    end
endmodule

`default_nettype wire

// ==== dv/windowed_watchdog_supervisor_tb.sv ====
// Self-checking bench for the watchdog supervisor, driving registers over the serial port.
`default_nettype none

module windowed_watchdog_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int PULSE = 20;

    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic spi_control_strap;
    logic window_size_strap_high;
    logic window_size_strap_low;
    logic [1:0] op_mode;
    logic do_edge;
    logic do_pulse;
    logic spi_sclk;
    logic spi_cs_n;
    logic spi_mosi;
    wire spi_miso;
    wire trigger_input;
    wire system_reset_out_n;
    wire watchdog_reset_out_n;
    wire interrupt_out_n;
    wire restart_active;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;
    logic [7:0] rd;

    // Short counts keep the run brief; expectations use the same figures.
    windowed_watchdog_supervisor #(.CYCLES_PER_MS(10), .RESET_PULSE_CYCLES(PULSE), .FILTER_CYCLES(2))
        windowed_watchdog_supervisor_inst (.clk(clk), .reset_n(reset_n), .spi_control_strap(spi_control_strap),
        .window_size_strap_high(window_size_strap_high), .window_size_strap_low(window_size_strap_low),
        .op_mode(op_mode), .trigger_input(trigger_input), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .system_reset_out_n(system_reset_out_n),
        .watchdog_reset_out_n(watchdog_reset_out_n), .interrupt_out_n(interrupt_out_n),
        .restart_active(restart_active));

    host_trigger_model #(.PULSE_GAP(PULSE)) host_trigger_model_inst (.clk(clk), .reset_n(reset_n),
        .do_edge(do_edge), .do_pulse(do_pulse), .trigger_input(trigger_input));

    // Free-running clock and a cycle ceiling that cuts a hang short.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("mismatches=%0d comparisons=%0d", err_total, samples_checked);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One frame: write flag and address, then data; read data is sampled on the rising edges of the second byte.
    task automatic spi_xfer(input logic wr, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] sh;
        sh = {wr, a, d};
        q = 8'h00;
        spi_cs_n = 1'b0;
        for (int i = 0; i < 16; i++) begin
            spi_mosi = sh[15 - i];
            tick(5);
            spi_sclk = 1'b1;
            if (i >= 8) q = {q[6:0], spi_miso};
            tick(5);
            spi_sclk = 1'b0;
        end
        tick(5);
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
        tick(10);
    endtask

    task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
        spi_xfer(1'b1, a, d, rd);
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        spi_xfer(1'b0, a, 8'h00, rd);
        check(rd, exp);
    endtask

    task automatic trig(input logic pulse);
        if (pulse) do_pulse = 1'b1;
        else do_edge = 1'b1;
        tick(1);
        do_edge = 1'b0;
        do_pulse = 1'b0;
    endtask

    // Main sequence; the window is 5120 cycles with its closed half first.
    initial begin
        spi_control_strap = 1'b1;
        window_size_strap_high = 1'b0;
        window_size_strap_low = 1'b1;
        op_mode = 2'h0;
        do_edge = 1'b0;
        do_pulse = 1'b0;
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
        tick(5);
        reset_n = 1'b1;
        tick(4);
        rd_chk(7'h13, 8'h80);
        rd_chk(7'h14, 8'h02);
        rd_chk(7'h16, 8'h00);
        rd_chk(7'h20, 8'h00);
        op_mode = 2'h1;
        wr_reg(7'h14, 8'he0);
        wr_reg(7'h13, 8'hb0);
        wr_reg(7'h16, 8'h40);
        tick(500);
        trig(1'b0);
        tick(10);
        check({7'h0, interrupt_out_n}, 8'h00);
        rd_chk(7'h14, 8'he4);
        wr_reg(7'h16, 8'h40);
        rd_chk(7'h14, 8'he2);
        wr_reg(7'h17, 8'h01);
        check({7'h0, interrupt_out_n}, 8'h01);
        tick(3140);
        trig(1'b0);
        rd_chk(7'h14, 8'he0);
        tick(3300);
        trig(1'b0);
        rd_chk(7'h14, 8'he0);
        tick(5200);
        rd_chk(7'h14, 8'he2);
        // Trip count one, then a trigger pulse whose return edge lands in the closed half.
        wr_reg(7'h16, 8'h00);
        tick(3300);
        trig(1'b1);
        n = 0;
        while (system_reset_out_n !== 1'b0 && n < 200) begin
            tick(1);
            n++;
        end
        check({7'h0, restart_active}, 8'h01);
        n = 0;
        while (system_reset_out_n !== 1'b1 && n < 200) begin
            tick(1);
            n++;
        end
        check(n[7:0], PULSE[7:0]);
        check({7'h0, restart_active}, 8'h00);
        rd_chk(7'h14, 8'he2);
        wr_reg(7'h13, 8'h70);
        tick(500);
        trig(1'b0);
        tick(10);
        rd_chk(7'h14, 8'he0);
        wr_reg(7'h13, 8'h30);
        tick(6000);
        rd_chk(7'h14, 8'he2);
        // Fast mode: an early trigger only raises the flag.
        wr_reg(7'h17, 8'h01);
        op_mode = 2'h3;
        wr_reg(7'h13, 8'hb0);
        tick(500);
        trig(1'b0);
        tick(10);
        check({6'h0, system_reset_out_n, interrupt_out_n}, 8'h02);
        rd_chk(7'h14, 8'he2);
        // Pin control with the strap tied to ground: 640-cycle window, closed for the first 320.
        op_mode = 2'h1;
        spi_control_strap = 1'b0;
        reset_n = 1'b0;
        tick(5);
        reset_n = 1'b1;
        tick(400);
        trig(1'b0);
        tick(20);
        check({7'h0, watchdog_reset_out_n}, 8'h01);
        tick(100);
        trig(1'b0);
        tick(12);
        check({6'h0, watchdog_reset_out_n, system_reset_out_n}, 8'h00);
        end_sim();
    end
endmodule

bind windowed_watchdog_supervisor wdt_supervisor_checker #(.RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) checker_inst (
    .clk(clk), .reset_n(reset_n), .spi_control_strap(spi_control_strap), .op_mode(op_mode),
    .system_reset_out_n(system_reset_out_n), .watchdog_reset_out_n(watchdog_reset_out_n),
    .interrupt_out_n(interrupt_out_n), .restart_active(restart_active));

`default_nettype wire
